// ==== abfp_params.svh ====
// constants for the asynchronous byte fifo port
`ifndef ABFP_PARAMS_SVH
`define ABFP_PARAMS_SVH
`define ABFP_DATA_W 8
`define ABFP_MODE_W 4
`define ABFP_MODE_ASYNC_FIFO 4'h1
`define ABFP_SYNC_STAGES 2
`define ABFP_BUF_DEPTH 2
`endif

// ==== abfp_pkg.sv ====
// types shared by the asynchronous byte fifo port
`default_nettype none
`include "abfp_params.svh"
package abfp_pkg;
  typedef logic [`ABFP_DATA_W-1:0] abfp_byte_t;
  // one byte with its valid flag, used on both usb-side streams
  typedef struct packed {
    logic valid;
    abfp_byte_t data;
  } abfp_beat_t;
  // two-way pin split into its drive value and enable
  typedef struct packed {
    abfp_byte_t dout;
    logic oe;
  } abfp_pad_out_t;
  typedef enum logic [1:0] {
    ABFP_RD_IDLE,
    ABFP_RD_DRIVE,
    ABFP_RD_GAP
  } abfp_rd_state_t;
endpackage
`default_nettype wire

// ==== abfp_buf2.sv ====
// two-entry byte buffer with valid/ready on both sides, registered read data
`timescale 1ns/100ps
`default_nettype none
module abfp_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  if (DEPTH != 2 || WIDTH < 1) begin : g_bad_params
    $error("abfp_buf2 serves only depth 2");
  end
  logic [WIDTH-1:0] head_r, head_nxt, tail_r, tail_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;
  assign in_ready_o = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o = head_r;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_comb begin
    head_nxt = head_r;
    tail_nxt = tail_r;
    cnt_nxt = cnt_r;
    unique case ({push, pop})
      2'b10: begin
        if (cnt_r == 2'h0) begin
          head_nxt = in_data_i;
        end else begin
          tail_nxt = in_data_i;
        end
        cnt_nxt = cnt_r + 2'h1;
      end
      2'b01: begin
        head_nxt = tail_r;
        cnt_nxt = cnt_r - 2'h1;
      end
      2'b11: begin
        if (cnt_r == 2'h1) begin
          head_nxt = in_data_i;
        end else begin
          head_nxt = tail_r;
          tail_nxt = in_data_i;
        end
      end
      default: begin
      end
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head_r <= '0;
      tail_r <= '0;
      cnt_r <= 2'h0;
    end else begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== abfp_port.sv ====
// asynchronous byte fifo port: strobe-driven parallel master interface
// Notes on behaviour
// - port acts only when configuration selects asynchronous fifo mode
// - data bus is input; driven only while read strobe is low (drive here follows the synchronised strobe, two cycles late at both edges)
// - receive-available low when a byte waits; master reads only then
// - after read strobe rises, receive-available goes high before next byte
// - during reset both status outputs are undriven, weakly pulled high
// - transmit-space low when a byte fits; master writes only then
// - read strobe falling edge presents head byte on the data bus
// - read strobe rising edge advances the receive buffer
// - write strobe falling edge captures bus byte into transmit buffer
// - suspended with wakeup enabled: send-now strobe requests usb resume
// - not suspended: send-now strobe flushes pending data on next bulk in
`timescale 1ns/100ps
`default_nettype none
`include "abfp_params.svh"
module abfp_port #(
  parameter int DATA_W = `ABFP_DATA_W,
  parameter int SYNC_STAGES = `ABFP_SYNC_STAGES
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // configuration from nonvolatile memory
  input wire logic [`ABFP_MODE_W-1:0] cfg_mode_i,
  input wire logic cfg_remote_wakeup_en_i,
  input wire logic usb_active_n_i,
  // pins
  input wire logic [DATA_W-1:0] parallel_data_bus_i,
  output logic [DATA_W-1:0] parallel_data_bus_o,
  output logic parallel_data_bus_oe_o,
  input wire logic rd_strobe_n_i,
  input wire logic wr_strobe_n_i,
  input wire logic send_now_wakeup_n_i,
  output logic rx_byte_available_n_o,
  output logic rx_byte_available_n_oe_o,
  output logic tx_space_available_n_o,
  output logic tx_space_available_n_oe_o,
  // receive stream from the usb side
  input wire abfp_pkg::abfp_beat_t rx_in_i,
  output logic rx_in_ready_o,
  // transmit stream to the usb side
  output abfp_pkg::abfp_beat_t tx_out_o,
  input wire logic tx_out_ready_i,
  output logic send_immediate_o,
  output logic resume_req_o
);
  import abfp_pkg::*;

  // elaboration stops here rather than building a port with the wrong widths
  if (DATA_W != `ABFP_DATA_W || SYNC_STAGES != 2) begin : g_bad_params
    $error("abfp_port serves only an 8-bit bus and two sync stages");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // strobes idle high, so they reset high to avoid a false edge
  logic [2:0] strb_s1_r, strb_s2_r, strb_d_r;
  logic [DATA_W-1:0] bus_s1_r, bus_s2_r;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strb_s1_r <= 3'h7;
      strb_s2_r <= 3'h7;
      strb_d_r <= 3'h7;
      bus_s1_r <= '0;
      bus_s2_r <= '0;
    end else begin
      strb_s1_r <= {send_now_wakeup_n_i, wr_strobe_n_i, rd_strobe_n_i};
      strb_s2_r <= strb_s1_r;
      strb_d_r <= strb_s2_r;
      bus_s1_r <= parallel_data_bus_i;
      bus_s2_r <= bus_s1_r;
    end
  end

  // mode check is decoded once and gates every strobe
  function automatic logic mode_is_async(input logic [`ABFP_MODE_W-1:0] m);
    return m == `ABFP_MODE_ASYNC_FIFO;
  endfunction

  logic enabled;
  logic rd_fall, rd_rise, wr_fall, sn_fall;
  assign enabled = mode_is_async(cfg_mode_i);
  assign rd_fall = enabled && strb_d_r[0] && !strb_s2_r[0];
  assign rd_rise = enabled && !strb_d_r[0] && strb_s2_r[0];
  assign wr_fall = enabled && strb_d_r[1] && !strb_s2_r[1];
  assign sn_fall = enabled && strb_d_r[2] && !strb_s2_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // receive path: buffer then read strobe

  logic rx_valid, rx_pop;
  logic [DATA_W-1:0] rx_head;
  abfp_buf2 #(
    .WIDTH(DATA_W),
    .DEPTH(`ABFP_BUF_DEPTH)
  ) u_rx_buf (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .in_valid_i(rx_in_i.valid),
    .in_ready_o(rx_in_ready_o),
    .in_data_i(rx_in_i.data),
    .out_valid_o(rx_valid),
    .out_ready_i(rx_pop),
    .out_data_o(rx_head)
  );

  abfp_rd_state_t rd_st_r, rd_st_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic rxf_n_r, rxf_n_nxt;
  always_comb begin
    rd_st_nxt = rd_st_r;
    dout_nxt = dout_r;
    rx_pop = 1'b0;
    rxf_n_nxt = rxf_n_r;
    unique case (rd_st_r)
      ABFP_RD_IDLE: begin
        rxf_n_nxt = !(rx_valid && enabled);
        if (rd_fall && rx_valid) begin
          dout_nxt = rx_head;
          rd_st_nxt = ABFP_RD_DRIVE;
        end
      end
      ABFP_RD_DRIVE: begin
        if (rd_rise) begin
          rx_pop = 1'b1;
          rxf_n_nxt = 1'b1;
          rd_st_nxt = ABFP_RD_GAP;
        end
      end
      ABFP_RD_GAP: begin
        // one cycle high so the master always sees the handshake close
        rxf_n_nxt = 1'b1;
        rd_st_nxt = ABFP_RD_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_st_r <= ABFP_RD_IDLE;
      dout_r <= '0;
      rxf_n_r <= 1'b1;
    end else begin
      rd_st_r <= rd_st_nxt;
      dout_r <= dout_nxt;
      rxf_n_r <= rxf_n_nxt;
    end
  end

  // bus drive follows the synchronised strobe, so it lags the pin by two cycles
  assign parallel_data_bus_o = dout_r;
  assign parallel_data_bus_oe_o = enabled && !strb_s2_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // transmit path: write strobe then buffer

  logic tx_ready, tx_push, tx_valid;
  logic [DATA_W-1:0] tx_data;
  assign tx_push = wr_fall && tx_ready;
  abfp_buf2 #(
    .WIDTH(DATA_W),
    .DEPTH(`ABFP_BUF_DEPTH)
  ) u_tx_buf (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .in_valid_i(tx_push),
    .in_ready_o(tx_ready),
    .in_data_i(bus_s2_r),
    .out_valid_o(tx_valid),
    .out_ready_i(tx_out_ready_i),
    .out_data_o(tx_data)
  );
  // one driver for the whole struct keeps the output a single variable
  assign tx_out_o = '{valid: tx_valid, data: tx_data};

  logic txe_n_r, txe_n_nxt;
  always_comb begin
    // held high while the strobe is low so a full buffer is seen before next write
    txe_n_nxt = !(enabled && tx_ready && strb_s2_r[1]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // send-immediate / wakeup

  logic sn_r, sn_nxt, rs_r, rs_nxt;
  always_comb begin
    sn_nxt = sn_fall && !usb_active_n_i;
    rs_nxt = sn_fall && usb_active_n_i && cfg_remote_wakeup_en_i;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      txe_n_r <= 1'b1;
      sn_r <= 1'b0;
      rs_r <= 1'b0;
    end else begin
      txe_n_r <= txe_n_nxt;
      sn_r <= sn_nxt;
      rs_r <= rs_nxt;
    end
  end
  assign send_immediate_o = sn_r;
  assign resume_req_o = rs_r;

  ////////////////////////////////////////////////////////////////////////////
  // status pins: driven only after reset, external pull-up holds them high until then

  assign rx_byte_available_n_o = rxf_n_r;
  assign tx_space_available_n_o = txe_n_r;
  assign rx_byte_available_n_oe_o = rst_n;
  assign tx_space_available_n_oe_o = rst_n;
endmodule
`default_nettype wire

// ==== abfp_port_chk.sv ====
// assertion checker for the asynchronous byte fifo port
`timescale 1ns/100ps
`default_nettype none
`include "abfp_params.svh"
module abfp_port_chk (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [`ABFP_MODE_W-1:0] cfg_mode_i,
  input wire logic cfg_remote_wakeup_en_i,
  input wire logic usb_active_n_i,
  input wire logic rd_strobe_n_i,
  input wire logic wr_strobe_n_i,
  input wire logic send_now_wakeup_n_i,
  input wire logic parallel_data_bus_oe_o,
  input wire logic rx_byte_available_n_o,
  input wire logic rx_byte_available_n_oe_o,
  input wire logic tx_space_available_n_o,
  input wire logic tx_space_available_n_oe_o,
  input wire abfp_pkg::abfp_beat_t tx_out_o,
  input wire logic send_immediate_o,
  input wire logic resume_req_o
);
  import abfp_pkg::*;
  logic on;
  assign on = (cfg_mode_i == `ABFP_MODE_ASYNC_FIFO);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_rx_high2;
    rx_byte_available_n_o [*2];
  endsequence
  sequence s_sn_fell;
    $fell(send_now_wakeup_n_i) && on;
  endsequence
  chk_bus_drive_rd: assert property (parallel_data_bus_oe_o |-> on && !$past(rd_strobe_n_i, 2))
    else $error("bus driven without read strobe");
  chk_rx_after_rd: assert property ($rose(rd_strobe_n_i) && on |-> ##[1:5] s_rx_high2)
    else $error("receive flag not high after read");
  chk_status_reset: assert property ($rose(resetn_i) |->
    !rx_byte_available_n_oe_o && !tx_space_available_n_oe_o
    ##3 rx_byte_available_n_oe_o && tx_space_available_n_oe_o)
    else $error("status pins driven in reset");
  chk_send_flush: assert property ((s_sn_fell and !usb_active_n_i) |-> ##[2:6] send_immediate_o)
    else $error("no flush pulse");
  chk_wake_resume: assert property ((s_sn_fell and (usb_active_n_i && cfg_remote_wakeup_en_i))
    |-> ##[2:6] resume_req_o)
    else $error("no resume pulse");
  chk_resume_cause: assert property (resume_req_o |-> usb_active_n_i && cfg_remote_wakeup_en_i)
    else $error("resume without suspend and wake enable");
  chk_mode_gate: assert property ((!on) [*4] |-> !parallel_data_bus_oe_o
    && !send_immediate_o && !resume_req_o)
    else $error("port active outside its mode");
  chk_write_push: assert property ($fell(wr_strobe_n_i) && on && !tx_space_available_n_o
    |-> ##[2:6] tx_out_o.valid)
    else $error("written byte not pushed");
endmodule
bind abfp_port abfp_port_chk u_chk (.ref_clk_i, .resetn_i, .cfg_mode_i, .cfg_remote_wakeup_en_i,
  .usb_active_n_i, .rd_strobe_n_i, .wr_strobe_n_i, .send_now_wakeup_n_i, .parallel_data_bus_oe_o,
  .rx_byte_available_n_o, .rx_byte_available_n_oe_o, .tx_space_available_n_o,
  .tx_space_available_n_oe_o, .tx_out_o, .send_immediate_o, .resume_req_o);
`default_nettype wire

// ==== abfp_master.sv ====
// behavioural parallel master on the far side of the port
`timescale 1ns/100ps
`default_nettype none
module abfp_master (
  input wire logic clk_i,
  input wire logic rx_n_i,
  input wire logic tx_n_i,
  input wire logic [7:0] bus_i,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic send_now_wakeup_n_n_o,
  output logic [7:0] drv_o,
  output logic drv_en_o
);
  import abfp_pkg::*;
  logic [1:0] rx_s;
  logic [1:0] tx_s;
  initial begin
    rd_n_o = 1'h1;
    wr_n_o = 1'h1;
    send_now_wakeup_n_n_o = 1'h1;
    drv_en_o = 1'h0;
    drv_o = 8'h00;
  end
  // status pins move off our clock, so they pass two flops first
  always @(posedge clk_i) begin
    rx_s <= {rx_s[0], rx_n_i};
    tx_s <= {tx_s[0], tx_n_i};
  end
  // wt low makes a refused access on purpose
  task automatic rd_byte(input bit wt, output abfp_byte_t b);
    int n = 0;
    while (wt && rx_s[1] !== 1'h0 && n < 99) begin
      @(posedge clk_i);
      n++;
    end
    // no separate output enable on this port: the read strobe turns the bus, and only in asynchronous fifo mode
    rd_n_o <= 1'h0;
    repeat (6) @(posedge clk_i);
    b = bus_i;
    rd_n_o <= 1'h1;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic wr_byte(input bit wt, input abfp_byte_t b);
    int n = 0;
    while (wt && tx_s[1] !== 1'h0 && n < 99) begin
      @(posedge clk_i);
      n++;
    end
    drv_o <= b;
    drv_en_o <= 1'h1;
    repeat (3) @(posedge clk_i);
    wr_n_o <= 1'h0;
    repeat (6) @(posedge clk_i);
    wr_n_o <= 1'h1;
    repeat (3) @(posedge clk_i);
    drv_en_o <= 1'h0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic send_now();
    send_now_wakeup_n_n_o <= 1'h0;
    repeat (5) @(posedge clk_i);
    send_now_wakeup_n_n_o <= 1'h1;
    repeat (8) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== abfp_port_tb_top.sv ====
// testbench for the asynchronous byte fifo port
`timescale 1ns/100ps
`default_nettype none
module abfp_port_tb_top;
  import abfp_pkg::*;
  logic ref_clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic [3:0] mode = 4'h1;
  logic wake_en = 1'h0;
  logic usb_n = 1'h0;
  logic tx_rdy = 1'h0;
  abfp_beat_t rx_in = '0;
  abfp_beat_t tx_out;
  logic [7:0] dout, md, bus;
  logic [7:0] bus_q = 8'h00;
  logic oe, men, rd_n, wr_n, sn_n, rxn, rxn_oe, txn, txn_oe, s_imm, res, rx_rdy, rx_pin, tx_pin;
  int n_errors = 0, cmp_count = 0, n_imm = 0, n_res = 0, cyc = 0;
  abfp_byte_t tx_q[$];
  // a released bus toggles so stale data never looks valid
  assign bus = oe ? dout : (men ? md : ~bus_q);
  assign rx_pin = rxn_oe ? rxn : 1'h1;
  assign tx_pin = txn_oe ? txn : 1'h1;
  abfp_port u_dut (.ref_clk_i, .resetn_i, .cfg_mode_i(mode), .cfg_remote_wakeup_en_i(wake_en),
    .usb_active_n_i(usb_n), .parallel_data_bus_i(bus), .parallel_data_bus_o(dout),
    .parallel_data_bus_oe_o(oe), .rd_strobe_n_i(rd_n), .wr_strobe_n_i(wr_n),
    .send_now_wakeup_n_i(sn_n), .rx_byte_available_n_o(rxn), .rx_byte_available_n_oe_o(rxn_oe),
    .tx_space_available_n_o(txn), .tx_space_available_n_oe_o(txn_oe), .rx_in_i(rx_in),
    .rx_in_ready_o(rx_rdy), .tx_out_o(tx_out), .tx_out_ready_i(tx_rdy),
    .send_immediate_o(s_imm), .resume_req_o(res));
  abfp_master u_mst (.clk_i(ref_clk_i), .rx_n_i(rx_pin), .tx_n_i(tx_pin), .bus_i(bus),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .send_now_wakeup_n_n_o(sn_n), .drv_o(md), .drv_en_o(men));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    bus_q <= bus;
    cyc <= cyc + 1;
    if (s_imm) n_imm <= n_imm + 1;
    if (res) n_res <= n_res + 1;
    if (tx_out.valid && tx_rdy) tx_q.push_back(tx_out.data);
    if (cyc == 5000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic push(input abfp_byte_t b);
    rx_in <= '{valid: 1'h1, data: b};
    do @(negedge ref_clk_i); while (rx_rdy !== 1'h1);
    @(posedge ref_clk_i);
  endtask
  task automatic t_rx();
    abfp_byte_t b;
    fork
      begin
        for (int i = 0; i < 3; i++) push(8'hA0 + 8'(i));
        rx_in <= '0;
      end
      for (int j = 0; j < 3; j++) begin
        u_mst.rd_byte(1'h1, b);
        chk(b, 8'hA0 + 8'(j));
      end
    join
    repeat (4) @(posedge ref_clk_i);
    chk(8'(rx_pin), 8'h1);
    u_mst.rd_byte(1'h0, b);
    chk(b, 8'hA2);
    chk(8'(rx_pin), 8'h1);
    chk(8'(oe), 8'h0);
  endtask
  task automatic t_tx();
    for (int i = 0; i < 3; i++) u_mst.wr_byte(1'h0, 8'h51 + 8'(i));
    chk(8'(tx_pin), 8'h1);
    tx_rdy <= 1'h1;
    repeat (8) @(posedge ref_clk_i);
    chk(8'(tx_q.size()), 8'h2);
    chk(tx_q[0], 8'h51);
    chk(tx_q[1], 8'h52);
    u_mst.wr_byte(1'h1, 8'h7E);
    chk(8'(tx_pin), 8'h0);
    chk(tx_q[2], 8'h7E);
  endtask
  task automatic t_send_now_wakeup_n();
    logic [1:0] cfg [3] = '{2'h0, 2'h3, 2'h2};
    int i0, r0;
    for (int i = 0; i < 3; i++) begin
      {usb_n, wake_en} <= cfg[i];
      @(posedge ref_clk_i);
      i0 = n_imm;
      r0 = n_res;
      u_mst.send_now();
      chk(8'(n_imm - i0), {7'h0, ~cfg[i][1]});
      chk(8'(n_res - r0), {7'h0, &cfg[i]});
    end
    usb_n <= 1'h0;
  endtask
  task automatic t_mode();
    abfp_byte_t b;
    mode <= 4'h0;
    repeat (4) @(posedge ref_clk_i);
    fork
      u_mst.rd_byte(1'h0, b);
      begin
        repeat (5) @(posedge ref_clk_i);
        chk(8'(oe), 8'h0);
      end
    join
    u_mst.wr_byte(1'h0, 8'h3C);
    u_mst.send_now();
    chk(8'(tx_q.size()), 8'h3);
    chk(8'(n_imm + n_res), 8'h2);
    mode <= 4'h1;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_i);
    chk(8'(rx_pin), 8'h1);
    chk(8'(txn_oe), 8'h0);
    resetn_i <= 1'h1;
    repeat (6) @(posedge ref_clk_i);
    chk(8'(rx_pin), 8'h1);
    chk(8'(tx_pin), 8'h0);
    t_rx();
    t_tx();
    t_send_now_wakeup_n();
    t_mode();
    end_of_test();
  end
endmodule
`default_nettype wire
